// >>> bench/ascf_channel_monitor.sv
// Port checker for the async serial channel
`timescale 1ns/1ps
module ascf_channel_monitor (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        data_wr_in,
  input wire logic        tx_en_in,
  input wire logic        tx_fifo_clr_in,
  input wire logic        xcvr_en_in,
  input wire logic        dce_mode_in,
  input wire logic [31:0] thr_out,
  input wire logic [31:0] fifo_count_out,
  input wire logic [3:0]  tx_flags_n_out,
  input wire logic [3:0]  rx_flags_n_out,
  input wire logic [7:0]  irq_status_out,
  input wire logic        board_interrupt_line_out,
  input wire logic        dma_tx_req_out,
  input wire logic        dma_rx_req_out,
  input wire logic        txd_pin_oe_out,
  input wire logic        rts_pin_oe_out,
  input wire logic        rxd_pin_oe_out
);
  // ----
  // Relations
  // ----
  wire [15:0] txc = fifo_count_out[15:0];
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_dte; (xcvr_en_in && !dce_mode_in) [*2]; endsequence
  property p_dte; s_dte |-> txd_pin_oe_out && rts_pin_oe_out && !rxd_pin_oe_out; endproperty
  property p_empty; tx_flags_n_out[0] == (txc != 0)
    && rx_flags_n_out[0] == (fifo_count_out[31:16] != 0); endproperty
  property p_aempty; $stable(thr_out) |-> tx_flags_n_out[2] == (txc > thr_out[15:0]); endproperty
  property p_afull; $stable(thr_out) |->
    tx_flags_n_out[3] == ({16'h0000, txc} + thr_out[31:16] < 32'h0000_8000); endproperty
  property p_push; data_wr_in && tx_flags_n_out[1] && !tx_en_in && !tx_fifo_clr_in
    |=> txc == $past(txc) + 16'h0001; endproperty
  property p_full; !tx_flags_n_out[1] && !tx_en_in && !tx_fifo_clr_in |=> $stable(txc); endproperty
  property p_dma; dma_tx_req_out == tx_flags_n_out[1]
    && dma_rx_req_out == rx_flags_n_out[0]; endproperty
  property p_irq; board_interrupt_line_out == |$past(irq_status_out); endproperty
  a_dte: assert property (p_dte) else $error("dte pin enables wrong");
  a_empty: assert property (p_empty) else $error("empty flag wrong");
  a_aempty: assert property (p_aempty) else $error("almost empty flag wrong");
  a_afull: assert property (p_afull) else $error("almost full flag wrong");
  a_push: assert property (p_push) else $error("write not counted");
  a_full: assert property (p_full) else $error("full fifo count moved");
  a_dma: assert property (p_dma) else $error("demand request wrong");
  a_irq: assert property (p_irq) else $error("interrupt line wrong");
endmodule // ascf_channel_monitor
bind ascf_channel ascf_channel_monitor mon (.*);

// >>> bench/ascf_channel_test.sv
// Self-checking bench for the async serial channel
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module ascf_channel_test;
  logic clk_in = 0, rst_in = 1, tx_en_in = 0, rx_en_in = 0, par_en_in = 1, two_stop_in = 1;
  logic chk_stop2_in = 0, save_fe_in = 0, save_pe_in = 0, auto_cts_in = 0, xcvr_en_in = 1;
  logic dce_mode_in = 0, ext_lb_in = 0, int_lb_in = 0, tx_fifo_clr_in = 0, rx_fifo_clr_in = 0;
  logic data_wr_in = 0, data_rd_in = 0, thr_wr_in = 0, irq_clr_in = 0;
  logic [1:0] par_type_in = 0, txd_src_in = 0;
  logic [2:0] rts_src_in = 3'h3;
  logic [7:0] data_wr_in_byte_in = 0, gp_src_in = 8'h7B, irq_en_in = 8'h01, b;
  logic [7:0] irq_rise_in = 8'h01, irq_clr_mask_in = 8'h01;
  logic [15:0] baud_div_in = 0, inter_word_idle_count_in = 16'h0003;
  logic [31:0] thr_data_in = 0;
  int n_fail = 0, total_checks = 0, cyc = 0;
  wire [7:0] data_rd_out, irq_status_out, pin_status_out;
  wire [31:0] thr_out, fifo_count_out;
  wire [3:0] tx_flags_n_out, rx_flags_n_out, ch_status_out, general_purpose_pin_out;
  wire [3:0] general_purpose_pin_oe_out, general_purpose_pin_in = 4'h9;
  wire board_interrupt_line_out, dma_tx_req_out, dma_rx_req_out, gap_busy_out, frame_err_out;
  wire parity_err_out, txd_pin_out, txd_pin_oe_out, rxd_pin_out, rxd_pin_oe_out, rts_pin_out;
  wire rts_pin_oe_out, cts_pin_out, cts_pin_oe_out, rm_line, cts_pin_in;
  wire txd_pin_in = txd_pin_oe_out ? txd_pin_out : 1'b1;
  wire rxd_pin_in = rxd_pin_oe_out ? rxd_pin_out : rm_line;
  wire rts_pin_in = rts_pin_oe_out ? rts_pin_out : 1'b1;
  ascf_channel dut (.*);
  ascf_remote_model rm (.line_in(txd_pin_in), .par_en_in(par_en_in), .line_out(rm_line),
                        .cts_out(cts_pin_in));
  initial forever #12.5 clk_in = ~clk_in;
  // Hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      final_report;
    end
  end
  task automatic final_report;
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // n back-to-back pushes
  task automatic push(input int n);
    @(negedge clk_in) data_wr_in = 1;
    repeat (n) @(negedge clk_in) data_wr_in_byte_in++;
    data_wr_in = 0;
  endtask
  task automatic wr(input logic [7:0] v);
    data_wr_in_byte_in = v;
    push(1);
  endtask
  task automatic rd(output logic [7:0] v);
    @(negedge clk_in) data_rd_in = 1;
    @(negedge clk_in) data_rd_in = 0;
    v = data_rd_out;
  endtask
  task automatic thr(input logic [31:0] v);
    @(negedge clk_in) {thr_wr_in, thr_data_in} = {1'b1, v};
    @(negedge clk_in) thr_wr_in = 0;
    @(negedge clk_in);
  endtask
  task automatic wait_q(input int n);
    repeat (3000) if (rm.got_q.size() < n) @(negedge clk_in);
    `CHK("frames", 1'b1, rm.got_q.size() >= n)
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (20) @(negedge clk_in);
    rst_in = 0;
    `CHK("thr", 32'h0007_0007, thr_out)
    `CHK("txf", 4'b1010, tx_flags_n_out)
    push(7); `CHK("ae7", 1'b0, tx_flags_n_out[2])
    `CHK("dte", 3'b001, {rxd_pin_oe_out, cts_pin_oe_out, rts_pin_out})
    push(1); `CHK("ae8", 1'b1, tx_flags_n_out[2])
    push(32752); `CHK("af", 1'b1, tx_flags_n_out[3])
    push(1); `CHK("af", 1'b0, tx_flags_n_out[3])
    push(8); `CHK("txc", 16'h8000, fifo_count_out[15:0])
    `CHK("full", 1'b0, tx_flags_n_out[1])
    thr(32'h0100_8000); `CHK("aenow", 1'b0, tx_flags_n_out[2])
    @(negedge clk_in) tx_fifo_clr_in = 1;
    @(negedge clk_in) tx_fifo_clr_in = 0;
    repeat (2) @(negedge clk_in);
    `CHK("clr", 4'b1010, tx_flags_n_out)
    `CHK("irq", 2'b11, {irq_status_out[0], board_interrupt_line_out})
    @(negedge clk_in) irq_clr_in = 1;
    @(negedge clk_in) irq_clr_in = 0;
    @(negedge clk_in) `CHK("irqc", 1'b0, irq_status_out[0])
    thr(32'h0007_0007);
    tx_en_in = 1;
    for (int t = 0; t < 4; t++) begin
      par_type_in = t[1:0];
      b = 8'hA4 + t[7:0];
      wr(b); wait_q(t + 1);
      `CHK("txb", b, rm.got_q[t])
      `CHK("par", t[1] ? t[0] : ^b ^ t[0], rm.par_q[t])
    end
    push(2); wait_q(6); `CHK("gap", 5, rm.gap_bits)
    repeat (40) @(negedge clk_in);
    `CHK("gapb", 1'b1, gap_busy_out)
    auto_cts_in = 1; rm.cts_out = 0; wr(8'h5A);
    repeat (400) @(negedge clk_in);
    `CHK("cts", 16'h0001, fifo_count_out[15:0])
    `CHK("chs", 4'h8, ch_status_out)
    rm.cts_out = 1; wait_q(7); `CHK("ctsb", 8'h5A, rm.got_q[6])
    par_en_in = 0; rx_en_in = 1; rm.send(8'h3C);
    repeat (40) @(negedge clk_in);
    `CHK("rxc", 16'h0001, fifo_count_out[31:16])
    `CHK("rxerr", 2'b00, {frame_err_out, parity_err_out})
    `CHK("drx", 1'b1, dma_rx_req_out)
    rd(b); `CHK("rxb", 8'h3C, b)
    int_lb_in = 1; wr(8'hC3); wait_q(8);
    repeat (40) @(negedge clk_in);
    rd(b); `CHK("lb", 8'hC3, b)
    rx_en_in = 0; rd(b); `CHK("rd0", 8'hC3, b)
    `CHK("gp", 7'h3D, {general_purpose_pin_oe_out, general_purpose_pin_out[2:0]})
    `CHK("gps", 4'h9, pin_status_out[3:0])
    dce_mode_in = 1; repeat (2) @(negedge clk_in);
    `CHK("dce", 3'b011, {txd_pin_oe_out, rxd_pin_oe_out, cts_pin_out})
    final_report;
  end
endmodule // ascf_channel_test

// >>> bench/ascf_remote_model.sv
// Remote serial equipment at the cable end
`timescale 1ns/1ps
module ascf_remote_model #(parameter int BIT_NS = 400) (
  input  wire logic line_in,
  input  wire logic par_en_in,
  output logic      line_out,
  output logic      cts_out
);
  logic [7:0] got_q[$];
  logic [7:0] d;
  logic       par_q[$];
  int         gap_bits;
  realtime    t_end = 0;
  // Receiver: centre sampling, idle high time between frames measured
  initial begin
    line_out = 1'b1;
    cts_out = 1'b1;
    forever begin
      @(negedge line_in);
      if (t_end > 0) gap_bits = $rtoi(($realtime - t_end) / BIT_NS + 0.5);
      #(BIT_NS * 1.5);
      repeat (8) begin
        d = {line_in, d[7:1]};
        #(BIT_NS);
      end
      par_q.push_back(par_en_in & line_in);
      if (par_en_in) #(BIT_NS);
      got_q.push_back(d);
      t_end = $realtime - BIT_NS / 2;
    end
  end
  // Sender: start, eight bits, two stop bits, no parity
  task automatic send(input logic [7:0] v);
    line_out = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      line_out = v[i];
      #(BIT_NS);
    end
    line_out = 1'b1;
    #(BIT_NS * 2);
  endtask
endmodule // ascf_remote_model

// >>> pkg/ascf_regs.vh
// Constants for the async serial channel with deep FIFOs
`ifndef ASCF_REGS_VH
`define ASCF_REGS_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define ASCF_CLK_HZ      40000000
`define ASCF_BAUD_REF_HZ 20000000
`define ASCF_PRE_CYC     (`ASCF_CLK_HZ / `ASCF_BAUD_REF_HZ)
`define ASCF_OVS_LAST    3'h7
`define ASCF_OVS_MID     3'h3
// ----------------------------------------
// FIFO geometry and thresholds
// ----------------------------------------
`define ASCF_FIFO_DEPTH  17'h0_8000
`define ASCF_FIFO_AW     15
`define ASCF_THR_RST     32'h0007_0007
`define ASCF_THR_AE_LSB  0
`define ASCF_THR_AF_LSB  16
// ----------------------------------------
// Field encodings
// ----------------------------------------
`define ASCF_PAR_EVEN    2'h0
`define ASCF_PAR_ODD     2'h1
`define ASCF_PAR_SPACE   2'h2
`define ASCF_PAR_MARK    2'h3
`define ASCF_TXS_UART    2'h0
`define ASCF_TXS_LO      2'h2
`define ASCF_TXS_HI      2'h3
`define ASCF_RTS_LO      3'h2
`define ASCF_RTS_HI      3'h3
`define ASCF_RTS_RXEN    3'h4
`define ASCF_RTS_NAF     3'h5
`define ASCF_GP_IN       2'h1
`define ASCF_GP_OUT0     2'h2
`define ASCF_GP_OUT1     2'h3
`endif

// >>> rtl/ascf_channel.v
// One async serial channel: framing, pins, FIFOs, flags, events
// Overview of operation
// - Eight data bits, least significant first
// - Optional even, odd, mark, space parity bit
// - One or two stop bits sent
// - Gap idle bits sent as stop bits
// - RTS/CTS let remote hold off transmitter
// - Data write pushes transmit, read pops receive
// - Four flags per FIFO, low when true
// - Flags are live status and interrupt sources
// - Almost empty while count at most threshold
// - Almost full while count at least size-threshold
// - Thresholds reset to seven each
// - Threshold change takes effect at once
// - Live byte count per FIFO
// - Each FIFO is 32K bytes deep
// - Board reset clears registers and FIFOs
// - Baud reference defaults to twenty megahertz
// - DTE/DCE swaps pin directions; GPIO separate
// - External loopback receives from driven pins
// - Internal loopback inside; pins still driven
// - GPIO outputs follow source; inputs readable
// - Demand requests: receive nonempty, transmit nonfull
// - Event latched until write-one clear or disable
// - Events edge triggered, rising or falling selectable
// - Auto CTS: start word only when active
// - Gap count is sixteen bits wide
`timescale 1ns/1ps
`include "ascf_regs.vh"
module ascf_channel (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire [15:0] baud_div_in,
  input  wire        tx_en_in,
  input  wire        rx_en_in,
  input  wire        par_en_in,
  input  wire [1:0]  par_type_in,
  input  wire        two_stop_in,
  input  wire        chk_stop2_in,
  input  wire        save_fe_in,
  input  wire        save_pe_in,
  input  wire        auto_cts_in,
  input  wire [2:0]  rts_src_in,
  input  wire [1:0]  txd_src_in,
  input  wire [15:0] inter_word_idle_count_in,
  input  wire        xcvr_en_in,
  input  wire        dce_mode_in,
  input  wire        ext_lb_in,
  input  wire        int_lb_in,
  input  wire [7:0]  gp_src_in,
  input  wire        tx_fifo_clr_in,
  input  wire        rx_fifo_clr_in,
  input  wire        data_wr_in,
  input  wire [7:0]  data_wr_in_byte_in,
  input  wire        data_rd_in,
  input  wire        thr_wr_in,
  input  wire [31:0] thr_data_in,
  input  wire [7:0]  irq_en_in,
  input  wire [7:0]  irq_rise_in,
  input  wire        irq_clr_in,
  input  wire [7:0]  irq_clr_mask_in,
  input  wire        txd_pin_in,
  input  wire        rxd_pin_in,
  input  wire        rts_pin_in,
  input  wire        cts_pin_in,
  input  wire [3:0]  general_purpose_pin_in,
  output wire [7:0]  data_rd_out,
  output reg  [31:0] thr_out,
  output wire [31:0] fifo_count_out,
  output wire [3:0]  tx_flags_n_out,
  output wire [3:0]  rx_flags_n_out,
  output reg  [7:0]  irq_status_out,
  output reg         board_interrupt_line_out,
  output wire        dma_tx_req_out,
  output wire        dma_rx_req_out,
  output reg  [7:0]  pin_status_out,
  output reg  [3:0]  ch_status_out,
  output reg         gap_busy_out,
  output reg         frame_err_out,
  output reg         parity_err_out,
  output reg         txd_pin_out,
  output reg         txd_pin_oe_out,
  output reg         rxd_pin_out,
  output reg         rxd_pin_oe_out,
  output reg         rts_pin_out,
  output reg         rts_pin_oe_out,
  output reg         cts_pin_out,
  output reg         cts_pin_oe_out,
  output reg  [3:0]  general_purpose_pin_out,
  output reg  [3:0]  general_purpose_pin_oe_out
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] TX_IDLE = 3'h0, TX_LOAD = 3'h1, TX_START = 3'h2, TX_DATA = 3'h3,
                   TX_PAR  = 3'h4, TX_STOP = 3'h5, TX_GAP   = 3'h6;
  localparam [2:0] RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2, RX_PAR = 3'h3,
                   RX_STOP = 3'h4, RX_STOP2 = 3'h5;
  localparam [31:0] PRE_LAST = `ASCF_PRE_CYC - 1;

  // Parity bit for a byte under the selected type
  function par_bit;
    input [7:0] d;
    input [1:0] t;
    begin
      case (t)
        `ASCF_PAR_EVEN:  par_bit = ^d;
        `ASCF_PAR_ODD:   par_bit = ~^d;
        `ASCF_PAR_SPACE: par_bit = 1'b0;
        default:         par_bit = 1'b1;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [7:0]  pre_ff;
  reg  [15:0] div_ff;
  reg         tick_ff;
  reg  [2:0]  tst_ff;
  reg  [2:0]  tovs_ff;
  reg  [7:0]  tsh_ff;
  reg  [7:0]  tbyte_ff;
  reg  [2:0]  tbit_ff;
  reg  [15:0] tcnt_ff;
  reg         tline_ff;
  reg         tx_pop;
  reg  [2:0]  rst_st_ff;
  reg  [2:0]  rovs_ff;
  reg  [7:0]  rsh_ff;
  reg  [2:0]  rbit_ff;
  reg         rperr_ff;
  reg         rfe_ff;
  reg         rx_push_ff;
  reg  [7:0]  rx_byte_ff;
  reg  [7:0]  cond_d_ff;
  wire        rts_int;
  wire        txd_int;
  wire        rx_line;
  wire        cts_line;
  wire [7:0]  cond;
  wire [7:0]  edge_ev;
  wire [16:0] tx_cnt;
  wire [16:0] rx_cnt;
  wire [7:0]  tx_head;
  wire        bit_end;
  wire        rsamp;

  // ----------------------------------------
  // FIFOs
  // ----------------------------------------
  ascf_fifo u_tx_fifo (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .clr_in       (tx_fifo_clr_in),
    .wr_in        (data_wr_in),
    .wr_data_in   (data_wr_in_byte_in),
    .rd_in        (tx_pop),
    .ae_thr_in    (thr_out[15:0]),
    .af_thr_in    (thr_out[31:16]),
    .rd_data_out  (tx_head),
    .count_out    (tx_cnt),
    .empty_n_out  (tx_flags_n_out[0]),
    .full_n_out   (tx_flags_n_out[1]),
    .aempty_n_out (tx_flags_n_out[2]),
    .afull_n_out  (tx_flags_n_out[3])
  );

  ascf_fifo u_rx_fifo (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .clr_in       (rx_fifo_clr_in),
    .wr_in        (rx_push_ff),
    .wr_data_in   (rx_byte_ff),
    .rd_in        (data_rd_in),
    .ae_thr_in    (thr_out[15:0]),
    .af_thr_in    (thr_out[31:16]),
    .rd_data_out  (data_rd_out),
    .count_out    (rx_cnt),
    .empty_n_out  (rx_flags_n_out[0]),
    .full_n_out   (rx_flags_n_out[1]),
    .aempty_n_out (rx_flags_n_out[2]),
    .afull_n_out  (rx_flags_n_out[3])
  );

  // Live counts, receive high half, transmit low half
  assign fifo_count_out = {rx_cnt[15:0], tx_cnt[15:0]};

  // Demand-paced transfer requests
  assign dma_rx_req_out = rx_flags_n_out[0];
  assign dma_tx_req_out = tx_flags_n_out[1];

  // Almost thresholds, low half almost empty, high half almost full
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      thr_out <= `ASCF_THR_RST;
    end else if (thr_wr_in) begin
      thr_out <= thr_data_in;
    end
  end

  // ----------------------------------------
  // Oversample tick: 20 MHz reference over divider
  // ----------------------------------------
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_ff  <= 8'h00;
      div_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (pre_ff == PRE_LAST[7:0]) begin
        pre_ff <= 8'h00;
        if (div_ff >= baud_div_in) begin
          div_ff  <= 16'h0000;
          tick_ff <= 1'b1;
        end else begin
          div_ff <= div_ff + 16'h0001;
        end
      end else begin
        pre_ff <= pre_ff + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  assign bit_end = tick_ff & (tovs_ff == `ASCF_OVS_LAST);

  // Pop the next byte when allowed to start a word
  always @* begin
    tx_pop = (tst_ff == TX_IDLE) & tx_en_in & tx_flags_n_out[0] &
             (~auto_cts_in | cts_line);
  end

  // Word framing state machine
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tst_ff   <= TX_IDLE;
      tovs_ff  <= 3'h0;
      tsh_ff   <= 8'h00;
      tbyte_ff <= 8'h00;
      tbit_ff  <= 3'h0;
      tcnt_ff  <= 16'h0000;
      tline_ff <= 1'b1;
    end else begin
      if (tick_ff) begin
        tovs_ff <= tovs_ff + 3'h1;
      end
      case (tst_ff)
        TX_IDLE: begin
          tline_ff <= 1'b1;
          if (tx_pop) begin
            tst_ff <= TX_LOAD;
          end
        end
        TX_LOAD: begin
          tsh_ff   <= tx_head;
          tbyte_ff <= tx_head;
          tline_ff <= 1'b0;
          tovs_ff  <= 3'h0;
          tst_ff   <= TX_START;
        end
        TX_START: begin
          if (bit_end) begin
            tline_ff <= tsh_ff[0];
            tsh_ff   <= {1'b0, tsh_ff[7:1]};
            tbit_ff  <= 3'h0;
            tst_ff   <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (bit_end) begin
            tbit_ff <= tbit_ff + 3'h1;
            if (tbit_ff == 3'h7) begin
              tcnt_ff <= {15'h0000, two_stop_in};
              if (par_en_in) begin
                tline_ff <= par_bit(tbyte_ff, par_type_in);
                tst_ff   <= TX_PAR;
              end else begin
                tline_ff <= 1'b1;
                tst_ff   <= TX_STOP;
              end
            end else begin
              tline_ff <= tsh_ff[0];
              tsh_ff   <= {1'b0, tsh_ff[7:1]};
            end
          end
        end
        TX_PAR: begin
          if (bit_end) begin
            tline_ff <= 1'b1;
            tst_ff   <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (bit_end) begin
            if (tcnt_ff != 16'h0000) begin
              tcnt_ff <= tcnt_ff - 16'h0001;
            end else if (inter_word_idle_count_in != 16'h0000) begin
              tcnt_ff <= inter_word_idle_count_in;
              tst_ff  <= TX_GAP;
            end else begin
              tst_ff <= TX_IDLE;
            end
          end
        end
        TX_GAP: begin
          if (bit_end) begin
            tcnt_ff <= tcnt_ff - 16'h0001;
            if (tcnt_ff == 16'h0001) begin
              tst_ff <= TX_IDLE;
            end
          end
        end
        default: tst_ff <= TX_IDLE;
      endcase
    end
  end

  // Line source selection
  assign txd_int = (txd_src_in == `ASCF_TXS_LO) ? 1'b0 :
                   (txd_src_in == `ASCF_TXS_HI) ? 1'b1 : tline_ff;
  assign rts_int = (rts_src_in == `ASCF_RTS_HI)   ? 1'b1 :
                   (rts_src_in == `ASCF_RTS_RXEN) ? rx_en_in :
                   (rts_src_in == `ASCF_RTS_NAF)  ? rx_flags_n_out[3] : 1'b0;

  // ----------------------------------------
  // Receive path selection
  // ----------------------------------------
  assign rx_line  = int_lb_in ? txd_int :
                    (ext_lb_in ? (dce_mode_in ? rxd_pin_in : txd_pin_in) :
                     (dce_mode_in ? txd_pin_in : rxd_pin_in));
  assign cts_line = int_lb_in ? rts_int :
                    (ext_lb_in ? (dce_mode_in ? cts_pin_in : rts_pin_in) :
                     (dce_mode_in ? rts_pin_in : cts_pin_in));
  assign rsamp    = tick_ff & (rovs_ff == `ASCF_OVS_MID);

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rst_st_ff      <= RX_IDLE;
      rovs_ff        <= 3'h0;
      rsh_ff         <= 8'h00;
      rbit_ff        <= 3'h0;
      rperr_ff       <= 1'b0;
      rfe_ff         <= 1'b0;
      rx_push_ff     <= 1'b0;
      rx_byte_ff     <= 8'h00;
      frame_err_out  <= 1'b0;
      parity_err_out <= 1'b0;
    end else begin
      rx_push_ff <= 1'b0;
      if (tick_ff) begin
        rovs_ff <= rovs_ff + 3'h1;
      end
      case (rst_st_ff)
        RX_IDLE: begin
          if (rx_en_in & tick_ff & ~rx_line) begin
            rovs_ff   <= 3'h1;
            rperr_ff  <= 1'b0;
            rfe_ff    <= 1'b0;
            rst_st_ff <= RX_START;
          end
        end
        RX_START: begin
          if (rsamp) begin
            rbit_ff   <= 3'h0;
            rst_st_ff <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rsamp) begin
            rsh_ff  <= {rx_line, rsh_ff[7:1]};
            rbit_ff <= rbit_ff + 3'h1;
            if (rbit_ff == 3'h7) begin
              rst_st_ff <= par_en_in ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rsamp) begin
            rperr_ff  <= rx_line ^ par_bit(rsh_ff, par_type_in);
            rst_st_ff <= RX_STOP;
          end
        end
        RX_STOP, RX_STOP2: begin
          if (rsamp) begin
            if ((rst_st_ff == RX_STOP) & two_stop_in & chk_stop2_in) begin
              rfe_ff    <= ~rx_line;
              rst_st_ff <= RX_STOP2;
            end else begin
              frame_err_out  <= rfe_ff | ~rx_line;
              parity_err_out <= rperr_ff;
              rx_byte_ff     <= rsh_ff;
              rx_push_ff     <= (save_fe_in | ~(rfe_ff | ~rx_line)) &
                                (save_pe_in | ~rperr_ff);
              rst_st_ff      <= RX_IDLE;
            end
          end
        end
        default: rst_st_ff <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Pins, direction and status
  // ----------------------------------------
  integer gi;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      txd_pin_out                <= 1'b1;
      txd_pin_oe_out             <= 1'b0;
      rxd_pin_out                <= 1'b1;
      rxd_pin_oe_out             <= 1'b0;
      rts_pin_out                <= 1'b0;
      rts_pin_oe_out             <= 1'b0;
      cts_pin_out                <= 1'b0;
      cts_pin_oe_out             <= 1'b0;
      general_purpose_pin_out    <= 4'h0;
      general_purpose_pin_oe_out <= 4'h0;
      pin_status_out             <= 8'h00;
      ch_status_out              <= 4'h0;
      gap_busy_out               <= 1'b0;
    end else begin
      txd_pin_out    <= txd_int;
      rxd_pin_out    <= txd_int;
      rts_pin_out    <= rts_int;
      cts_pin_out    <= rts_int;
      txd_pin_oe_out <= xcvr_en_in & ~dce_mode_in;
      rts_pin_oe_out <= xcvr_en_in & ~dce_mode_in;
      rxd_pin_oe_out <= xcvr_en_in & dce_mode_in;
      cts_pin_oe_out <= xcvr_en_in & dce_mode_in;
      for (gi = 0; gi < 4; gi = gi + 1) begin
        general_purpose_pin_oe_out[gi] <= xcvr_en_in & gp_src_in[2*gi+1];
        general_purpose_pin_out[gi]    <= gp_src_in[2*gi];
      end
      pin_status_out <= {cts_pin_in, rts_pin_in, rxd_pin_in, txd_pin_in,
                         general_purpose_pin_in};
      ch_status_out  <= {tx_en_in | (tst_ff != TX_IDLE), tst_ff != TX_IDLE,
                         rx_en_in | (rst_st_ff != RX_IDLE), rst_st_ff != RX_IDLE};
      gap_busy_out   <= (tst_ff == TX_GAP);
    end
  end

  // ----------------------------------------
  // Flag events: edge detect, latch, clear
  // ----------------------------------------
  assign cond    = ~{rx_flags_n_out, tx_flags_n_out};
  assign edge_ev = (irq_rise_in & cond & ~cond_d_ff) |
                   (~irq_rise_in & ~cond & cond_d_ff);

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cond_d_ff                <= 8'h55;   // Conditions of empty FIFOs, no false edge
      irq_status_out           <= 8'h00;
      board_interrupt_line_out <= 1'b0;
    end else begin
      cond_d_ff      <= cond;
      irq_status_out <= irq_en_in & ((edge_ev & irq_en_in) |
                        (irq_status_out & ~({8{irq_clr_in}} & irq_clr_mask_in)));
      board_interrupt_line_out <= |irq_status_out;
    end
  end
endmodule // ascf_channel

// >>> rtl/ascf_fifo.v
// Byte FIFO with live count and active-low status flags
`timescale 1ns/1ps
`include "ascf_regs.vh"
module ascf_fifo (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        clr_in,
  input  wire        wr_in,
  input  wire [7:0]  wr_data_in,
  input  wire        rd_in,
  input  wire [15:0] ae_thr_in,
  input  wire [15:0] af_thr_in,
  output reg  [7:0]  rd_data_out,
  output reg  [16:0] count_out,
  output reg         empty_n_out,
  output reg         full_n_out,
  output reg         aempty_n_out,
  output reg         afull_n_out
);
  reg  [7:0]                mem_ff [0:32767];
  reg  [`ASCF_FIFO_AW-1:0]  wp_ff;
  reg  [`ASCF_FIFO_AW-1:0]  rp_ff;
  wire                      do_wr;
  wire                      do_rd;
  reg  [16:0]               nxt_count;

  // Refuse push when full and pop when empty
  assign do_wr = wr_in & full_n_out;
  assign do_rd = rd_in & empty_n_out;

  // Next fill level
  always @* begin
    nxt_count = count_out;
    if (do_wr & ~do_rd) begin
      nxt_count = count_out + 17'h0_0001;
    end else if (do_rd & ~do_wr) begin
      nxt_count = count_out - 17'h0_0001;
    end
  end

  // Storage, no reset needed on data
  always @(posedge clk_in) begin
    if (do_wr) begin
      mem_ff[wp_ff] <= wr_data_in;
    end
  end

  // Pointers, count and flags
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_ff        <= 15'h0000;
      rp_ff        <= 15'h0000;
      count_out    <= 17'h0_0000;
      rd_data_out  <= 8'h00;
      empty_n_out  <= 1'b0;
      full_n_out   <= 1'b1;
      aempty_n_out <= 1'b0;
      afull_n_out  <= 1'b1;
    end else if (clr_in) begin
      wp_ff        <= 15'h0000;
      rp_ff        <= 15'h0000;
      count_out    <= 17'h0_0000;
      empty_n_out  <= 1'b0;
      full_n_out   <= 1'b1;
      aempty_n_out <= 1'b0;
      afull_n_out  <= 1'b1;
    end else begin
      if (do_wr) begin
        wp_ff <= wp_ff + 15'h0001;
      end
      if (do_rd) begin
        rp_ff       <= rp_ff + 15'h0001;
        rd_data_out <= mem_ff[rp_ff];
      end
      count_out    <= nxt_count;
      empty_n_out  <= (nxt_count != 17'h0_0000);
      full_n_out   <= (nxt_count != `ASCF_FIFO_DEPTH);
      aempty_n_out <= (nxt_count > {1'b0, ae_thr_in});
      // Sum form keeps a threshold above the depth from wrapping to "not almost full"
      afull_n_out  <= (({1'b0, nxt_count} + {2'b00, af_thr_in}) <
                       {1'b0, `ASCF_FIFO_DEPTH});
    end
  end
endmodule // ascf_fifo
